// ===== rtl/fsr_pkg.sv
package fsr_pkg;

    // Command opcodes seen on the serial link
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST   = 8'h99;

    // Register one bit positions
    localparam int B1_BUSY  = 0;
    localparam int B1_WEL   = 1;
    localparam int B1_RANGE = 2;
    localparam int B1_DIR   = 5;
    localparam int B1_GRAN  = 6;
    localparam int B1_GLO   = 7;

    // Register two bit positions
    localparam int B2_GHI   = 0;
    localparam int B2_QUAD  = 1;
    localparam int B2_PSUS  = 2;
    localparam int B2_LOCK  = 3;
    localparam int B2_INV   = 6;
    localparam int B2_ESUS  = 7;

    // Register three bit positions
    localparam int B3_DUMMY = 0;
    localparam int B3_DRV   = 5;
    localparam int B3_PINF  = 7;

    // Writable masks
    localparam logic [7:0] SR1_NV_MASK   = 8'hfc;
    localparam logic [7:0] SR2_NV_MASK   = 8'h43;
    localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
    localparam logic [7:0] SR3_NV_MASK   = 8'he1;

    // Values after reset
    localparam logic [7:0] SR_RESET = 8'h00;

    // Guard modes {reg_guard_high, reg_guard_low}
    localparam logic [1:0] GUARD_SOFT = 2'h0;
    localparam logic [1:0] GUARD_HW   = 2'h1;
    localparam logic [1:0] GUARD_LOCK = 2'h2;

    // Non-volatile write time in clk cycles
    localparam int unsigned NV_WRITE_CYCLES_DEF = 1000;

    typedef enum logic [0:0] {WR_IDLE, WR_NV} fsr_wr_e;

endpackage

// ===== rtl/fsr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsr_link_if;
    logic [7:0]  byte_data;
    logic        byte_tgl;
    logic [23:0] rd_word;
    modport link (output byte_data, output byte_tgl, input rd_word);
    modport core (input byte_data, input byte_tgl, output rd_word);
endinterface // fsr_link_if
`default_nettype wire

// ===== rtl/fsr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= RST;
            q      <= RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // fsr_sync
`default_nettype wire

// ===== rtl/fsr_link.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_link (
    // Serial pins
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic di,
    input  wire logic link_rst,
    output logic      spi_do,
    output logic      spi_do_oe,
    // Core side
    fsr_link_if.link  lnk
);
    logic [2:0]  cnt_r;
    logic [6:0]  sh_r;
    logic        first_r;
    logic        rd_act_r;
    logic [1:0]  rd_sel_r;
    logic [7:0]  out_sh_r;
    logic [23:0] word_s;
    logic [7:0]  byte_w;
    logic [7:0]  sel_byte;

    assign byte_w = {sh_r, di};

    // Core holds the read word still while selected, so per-bit sync is safe
    fsr_sync #(.W(24), .RST(24'h000000)) u_word_sync (
        .clk  (sck),
        .srst (1'b0),
        .d    (lnk.rd_word),
        .q    (word_s)
    );

    always_comb begin
        case (rd_sel_r)
            2'h1:    sel_byte = word_s[15:8];
            2'h2:    sel_byte = word_s[23:16];
            default: sel_byte = word_s[7:0];
        endcase
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_r    <= 3'h0;
            sh_r     <= 7'h00;
            first_r  <= 1'b1;
            rd_act_r <= 1'b0;
            rd_sel_r <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            sh_r  <= byte_w[6:0];
            if (cnt_r == 3'h7) begin
                first_r <= 1'b0;
                // R1: read opcode decode
                if (first_r) begin
                    rd_act_r <= (byte_w == fsr_pkg::OP_RDSR1) || (byte_w == fsr_pkg::OP_RDSR2) ||
                                (byte_w == fsr_pkg::OP_RDSR3);
                    rd_sel_r <= (byte_w == fsr_pkg::OP_RDSR2) ? 2'h1 :
                                (byte_w == fsr_pkg::OP_RDSR3) ? 2'h2 : 2'h0;
                end
            end
        end
    end

    // Every completed byte is handed over with a toggle
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            lnk.byte_data <= 8'h00;
            lnk.byte_tgl  <= 1'b0;
        end else if (!cs_n && cnt_r == 3'h7) begin
            lnk.byte_data <= byte_w;
            lnk.byte_tgl  <= ~lnk.byte_tgl;
        end
    end

    // Output shifts on falling edges, repeating the selected byte
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_sh_r  <= 8'h00;
            spi_do    <= 1'b0;
            spi_do_oe <= 1'b0;
        end else if (rd_act_r) begin
            spi_do_oe <= 1'b1;
            if (cnt_r == 3'h0) begin
                spi_do   <= sel_byte[7];
                out_sh_r <= {sel_byte[6:0], 1'b0};
            end else begin
                spi_do   <= out_sh_r[7];
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end
endmodule // fsr_link
`default_nettype wire

// ===== rtl/fsr_flash_status.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Host observes and changes settings only via read and write status commands.
// R2: Register-one bits 7..2 and register-two bits 6..3,1,0 are non-volatile.
// R3: Suspend, write-enable and busy bits are read-only; host writes ignore them.
// R4: Write-enable latch sets on write-enable command, clears when operation ends.
// R5: Status write needs guard permission, prior enable, and protect pin unless quad; the code checks the protect pin only in guard mode 01.
// R6: Volatile shadow of protection and quad bits governs operation.
// R7: Shadow reloads from non-volatile copy at power-up and software reset.
// R8: Volatile enable before status write updates only the shadow bits.
// R9: Granularity bit selects 64-KB blocks or 4-KB sectors.
// R10: Direction bit selects protection from top or from bottom.
// R11: Three-bit range field; value zero means nothing protected.
// R12: No embedded operation starts unless write-enable latch is one.
// R13: Busy bit is one while an embedded operation runs.
// R14: Erase and program suspend flags show suspended operations.
// R15: Invert bit complements the selected protection map.
// R16: Three one-time lock bits protect security registers three to one.
// R17: Quad enable turns protect and hold pins into data lines.
// R18: Two guard bits form the status protection mode.
// R19: Register-three bit 7 selects hold or reset pin, only without quad.
// R20: Register-three bits 6..5 select output drive strength.
// R21: Register-three bit 0 selects the dummy cycle count.
// R22: Guard mode 01 with protect pin low locks all status registers.
// R23: Latch clears at power-up and after disable, program, erase, status write.
// R24: While busy, only the read status command is honoured.
// R25: Lock-down guard mode returns to 00 on software reset.
// R26: Protected or read-only bits stay unchanged, command completes silently.
module fsr_flash_status #(
    parameter int unsigned NV_WRITE_CYCLES = fsr_pkg::NV_WRITE_CYCLES_DEF
) (
    // System
    input  wire logic       clk,
    input  wire logic       srst,
    // Serial link
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       di,
    output logic            spi_do,
    output logic            spi_do_oe,
    // Multiplexed pins
    input  wire logic       wp_n,
    input  wire logic       hold_n,
    // Program and erase engine
    input  wire logic       eng_busy,
    input  wire logic       eng_done,
    input  wire logic       erase_susp,
    input  wire logic       prog_susp,
    output logic            op_permit,
    output logic            busy,
    // Protection and pin configuration
    output logic            granularity_select,
    output logic            direction_select,
    output logic [2:0]      protect_range,
    output logic            invert_protection,
    output logic [2:0]      secure_lock,
    output logic            four_lane_enable,
    output logic            hold_active,
    output logic            hw_reset_req,
    output logic [1:0]      drive_strength,
    output logic            dummy_cycle_select
);

    fsr_link_if lnk ();

    logic [3:0]      pin_s;
    logic            cs_s;
    logic            tgl_s;
    logic            wp_s;
    logic            hold_s;
    logic            cs_d_r;
    logic            cs_d2_r;
    logic            tgl_d_r;
    logic            byte_ev;
    logic            frame_end;
    logic [1:0]      idx_r;
    logic [7:0]      op_r;
    logic            opc_ok_r;
    logic [7:0]      d0_r;
    logic [7:0]      d1_r;
    logic            op_acc;
    logic [7:0]      bd;
    logic [7:0]      nv1_r;
    logic [7:0]      nv2_r;
    logic [7:0]      nv3_r;
    logic [7:0]      v1_r;
    logic [7:0]      v2_r;
    logic [7:0]      v3_r;
    logic            wel_r;
    logic            vwe_r;
    logic            rst_en_r;
    logic            busy_r;
    logic            esus_r;
    logic            psus_r;
    logic            hold_active_r;
    logic            hw_reset_r;
    logic [23:0]     rd_word_r;
    fsr_pkg::fsr_wr_e wr_st_r;
    logic [31:0]     wr_cnt_r;
    logic            wr_cmd;
    logic [1:0]      guard;
    logic [1:0]      nv_guard;
    logic            guard_ok;
    logic            wr_ok;
    logic            nv_go;
    logic            vol_go;
    logic            en1;
    logic            en2;
    logic            en3;
    logic [7:0]      val2;
    logic            soft_rst;
    logic            lockdown;

    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    fsr_link u_link (
        .sck       (sck),
        .cs_n      (cs_n),
        .di        (di),
        .link_rst  (srst),
        .spi_do    (spi_do),
        .spi_do_oe (spi_do_oe),
        .lnk       (lnk.link)
    );

    // Chip select, byte toggle and multiplexed pins into clk
    fsr_sync #(.W(4), .RST(4'hb)) u_pin_sync (
        .clk  (clk),
        .srst (srst),
        .d    ({cs_n, lnk.byte_tgl, wp_n, hold_n}),
        .q    (pin_s)
    );
    assign {cs_s, tgl_s, wp_s, hold_s} = pin_s;

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_d_r  <= 1'b1;
            cs_d2_r <= 1'b1;
            tgl_d_r <= 1'b0;
        end else begin
            cs_d_r  <= cs_s;
            cs_d2_r <= cs_d_r;
            tgl_d_r <= tgl_s;
        end
    end

    // Frame end lags a cycle so the last byte is already counted
    assign byte_ev   = tgl_s ^ tgl_d_r;
    assign frame_end = cs_d_r & ~cs_d2_r;
    assign bd        = lnk.byte_data;
    assign lnk.rd_word = rd_word_r;

    // R24: busy gates opcodes
    assign op_acc = byte_ev && (idx_r == 2'h0) && !busy_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            idx_r    <= 2'h0;
            op_r     <= 8'h00;
            opc_ok_r <= 1'b0;
            d0_r     <= 8'h00;
            d1_r     <= 8'h00;
        end else if (byte_ev) begin
            if (idx_r == 2'h0) begin
                op_r     <= bd;
                opc_ok_r <= !busy_r;
            end else if (idx_r == 2'h1) begin
                d0_r <= bd;
            end else if (idx_r == 2'h2) begin
                d1_r <= bd;
            end
            if (idx_r != 2'h3) begin
                idx_r <= idx_r + 2'h1;
            end
        end else if (cs_d2_r) begin
            idx_r    <= 2'h0;
            opc_ok_r <= 1'b0;
        end
    end

    // R1: write status decode
    assign wr_cmd = opc_ok_r && (idx_r >= 2'h2) &&
                    (op_r == fsr_pkg::OP_WRSR1 || op_r == fsr_pkg::OP_WRSR2 || op_r == fsr_pkg::OP_WRSR3);
    assign en1  = (op_r == fsr_pkg::OP_WRSR1);
    assign en2  = (op_r == fsr_pkg::OP_WRSR1 && idx_r == 2'h3) || (op_r == fsr_pkg::OP_WRSR2);
    assign en3  = (op_r == fsr_pkg::OP_WRSR3);
    assign val2 = (op_r == fsr_pkg::OP_WRSR1) ? d1_r : d0_r;

    // R18: guard mode from shadow bits
    assign guard    = {v2_r[fsr_pkg::B2_GHI], v1_r[fsr_pkg::B1_GLO]};
    assign nv_guard = {nv2_r[fsr_pkg::B2_GHI], nv1_r[fsr_pkg::B1_GLO]};

    always_comb begin
        case (guard)
            fsr_pkg::GUARD_SOFT: guard_ok = 1'b1;
            // R22: protect pin lock
            fsr_pkg::GUARD_HW:   guard_ok = v2_r[fsr_pkg::B2_QUAD] || wp_s;
            default:             guard_ok = 1'b0;
        endcase
    end

    // R5: write permission
    assign wr_ok  = wr_cmd && (wel_r || vwe_r) && guard_ok;
    // R8: volatile write path
    assign nv_go  = frame_end && wr_ok && !vwe_r;
    assign vol_go = frame_end && wr_ok && vwe_r;

    assign soft_rst = op_acc && (bd == fsr_pkg::OP_RST) && rst_en_r;
    assign lockdown = (nv_guard == fsr_pkg::GUARD_LOCK);

    // R2: non-volatile copies; R26: masks keep protected bits
    always_ff @(posedge clk) begin
        if (srst) begin
            nv1_r <= fsr_pkg::SR_RESET;
            nv2_r <= fsr_pkg::SR_RESET;
            nv3_r <= fsr_pkg::SR_RESET;
        end else if (nv_go) begin
            if (en1) begin
                nv1_r <= merge(nv1_r, d0_r, fsr_pkg::SR1_NV_MASK);
            end
            // R16: lock bits only ever set
            if (en2) begin
                nv2_r <= merge(nv2_r, val2, fsr_pkg::SR2_NV_MASK) | (val2 & fsr_pkg::SR2_LOCK_MASK);
            end
            if (en3) begin
                nv3_r <= merge(nv3_r, d0_r, fsr_pkg::SR3_NV_MASK);
            end
        end else if (soft_rst && lockdown) begin
            // R25: lock-down released
            nv1_r[fsr_pkg::B1_GLO] <= 1'b0;
            nv2_r[fsr_pkg::B2_GHI] <= 1'b0;
        end
    end

    // R6: volatile shadow
    always_ff @(posedge clk) begin
        if (srst) begin
            v1_r <= fsr_pkg::SR_RESET;
            v2_r <= fsr_pkg::SR_RESET;
            v3_r <= fsr_pkg::SR_RESET;
        end else if (soft_rst) begin
            // R7: reload from non-volatile
            v1_r <= nv1_r & fsr_pkg::SR1_NV_MASK & ~(lockdown ? 8'h80 : 8'h00);
            v2_r <= nv2_r & fsr_pkg::SR2_NV_MASK & ~(lockdown ? 8'h01 : 8'h00);
            v3_r <= nv3_r & fsr_pkg::SR3_NV_MASK;
        end else if (nv_go || vol_go) begin
            if (en1) begin
                v1_r <= merge(v1_r, d0_r, fsr_pkg::SR1_NV_MASK);
            end
            if (en2) begin
                v2_r <= merge(v2_r, val2, fsr_pkg::SR2_NV_MASK);
            end
            if (en3) begin
                v3_r <= merge(v3_r, d0_r, fsr_pkg::SR3_NV_MASK);
            end
        end
    end

    // R4: latch set wins over clears; R23: clearing commands
    always_ff @(posedge clk) begin
        if (srst) begin
            wel_r <= 1'b0;
        end else if (op_acc && bd == fsr_pkg::OP_WREN) begin
            wel_r <= 1'b1;
        end else if (soft_rst || eng_done || (frame_end && wr_cmd) || (op_acc && bd == fsr_pkg::OP_WRDI)) begin
            wel_r <= 1'b0;
        end
    end

    // R8: volatile enable holds only into the next status write
    always_ff @(posedge clk) begin
        if (srst) begin
            vwe_r <= 1'b0;
        end else if (op_acc) begin
            vwe_r <= (bd == fsr_pkg::OP_VWREN) ||
                     (vwe_r && (bd == fsr_pkg::OP_WRSR1 || bd == fsr_pkg::OP_WRSR2 || bd == fsr_pkg::OP_WRSR3));
        end else if (frame_end && wr_cmd) begin
            vwe_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rst_en_r <= 1'b0;
        end else if (op_acc) begin
            rst_en_r <= (bd == fsr_pkg::OP_RSTEN);
        end
    end

    // Non-volatile write cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_st_r  <= fsr_pkg::WR_IDLE;
            wr_cnt_r <= 32'h0;
        end else begin
            case (wr_st_r)
                fsr_pkg::WR_IDLE: begin
                    wr_cnt_r <= 32'h0;
                    if (nv_go) begin
                        wr_st_r <= fsr_pkg::WR_NV;
                    end
                end
                fsr_pkg::WR_NV: begin
                    wr_cnt_r <= wr_cnt_r + 32'h1;
                    if (wr_cnt_r == NV_WRITE_CYCLES - 1) begin
                        wr_st_r <= fsr_pkg::WR_IDLE;
                    end
                end
                default: wr_st_r <= fsr_pkg::WR_IDLE;
            endcase
        end
    end

    // R13: busy flag; R14: suspend flags
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            esus_r <= 1'b0;
            psus_r <= 1'b0;
        end else begin
            busy_r <= eng_busy || nv_go || (wr_st_r == fsr_pkg::WR_NV);
            esus_r <= erase_susp;
            psus_r <= prog_susp;
        end
    end

    // R3: status bits come only from internal state
    // Held while selected so the link domain samples one steady word
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_word_r <= 24'h000000;
        end else if (cs_s) begin
            rd_word_r <= {v3_r & fsr_pkg::SR3_NV_MASK,
                          esus_r, v2_r[6], nv2_r[5:3], psus_r, v2_r[1:0],
                          v1_r[7:2], wel_r, busy_r};
        end
    end

    // R17: pin functions off in quad; R19: hold or reset
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_active_r <= 1'b0;
            hw_reset_r    <= 1'b0;
        end else begin
            hold_active_r <= !v2_r[fsr_pkg::B2_QUAD] && !v3_r[fsr_pkg::B3_PINF] && !hold_s;
            hw_reset_r    <= !v2_r[fsr_pkg::B2_QUAD] && v3_r[fsr_pkg::B3_PINF] && !hold_s;
        end
    end

    // R12: engine may start only with latch set
    assign op_permit = wel_r;
    assign busy      = busy_r;
    // R9: granularity select
    assign granularity_select = v1_r[fsr_pkg::B1_GRAN];
    // R10: direction select
    assign direction_select   = v1_r[fsr_pkg::B1_DIR];
    // R11: range field
    assign protect_range      = v1_r[fsr_pkg::B1_RANGE +: 3];
    // R15: map inversion
    assign invert_protection  = v2_r[fsr_pkg::B2_INV];
    // R16: security locks
    assign secure_lock        = nv2_r[fsr_pkg::B2_LOCK +: 3];
    assign four_lane_enable   = v2_r[fsr_pkg::B2_QUAD];
    assign hold_active        = hold_active_r;
    assign hw_reset_req       = hw_reset_r;
    // R20: drive strength
    assign drive_strength     = v3_r[fsr_pkg::B3_DRV +: 2];
    // R21: dummy cycles
    assign dummy_cycle_select = v3_r[fsr_pkg::B3_DUMMY];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_busy_follow_engine: assert property (eng_busy |=> busy_r) else $error("busy not set by engine"); // R13
    a_wel_set_cmd: assert property (op_acc && bd == fsr_pkg::OP_WREN |=> wel_r) else $error("latch not set"); // R4
    a_wel_clr_done: assert property (eng_done && !(op_acc && bd == fsr_pkg::OP_WREN) |=> !wel_r)
        else $error("latch not cleared at done"); // R23
    a_nv_needs_wel: assert property ($rose(wr_st_r == fsr_pkg::WR_NV) |-> $past(wel_r, 2))
        else $error("write started without latch"); // R12
    a_hw_guard_lock: assert property (frame_end && wr_cmd && guard == fsr_pkg::GUARD_HW &&
        !v2_r[fsr_pkg::B2_QUAD] && !wp_s |=> v1_r == $past(v1_r) && nv1_r == $past(nv1_r) &&
        v3_r == $past(v3_r)) else $error("locked registers changed"); // R22
    a_vol_only: assert property (vol_go |=> nv1_r == $past(nv1_r) && nv2_r == $past(nv2_r) &&
        nv3_r == $past(nv3_r)) else $error("volatile write touched storage"); // R8
    a_reload_shadow: assert property (soft_rst |=> v1_r[6:2] == $past(nv1_r[6:2]) &&
        v2_r[fsr_pkg::B2_INV] == $past(nv2_r[fsr_pkg::B2_INV])) else $error("shadow not reloaded"); // R7
    a_lockdown_drop: assert property (soft_rst && lockdown |=> guard == 2'h0 && nv_guard == 2'h0)
        else $error("lock-down kept"); // R25
    a_busy_ignore: assert property (byte_ev && idx_r == 2'h0 && busy_r && !wel_r |=> !wel_r)
        else $error("command taken while busy"); // R24
    a_susp_visible: assert property (erase_susp |=> ##1 rd_word_r[15]) else $error("suspend not shown"); // R14
    a_quad_pins_off: assert property (v2_r[fsr_pkg::B2_QUAD] |=> !hold_active_r && !hw_reset_r)
        else $error("pin function in quad"); // R17

    c_nv_write: cover property (nv_go ##1 wr_st_r == fsr_pkg::WR_NV);
    c_vol_write: cover property (vol_go);
    c_soft_reset: cover property (soft_rst);

endmodule // fsr_flash_status
`default_nettype wire

// ===== test/fsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
    // Serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      di,
    input  wire logic spi_do
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        di   = 1'b0;
    end
    task automatic frame(input logic [23:0] tx, input int nb, output logic [7:0] rx);
        int i;
        rx   = 8'h00;
        cs_n = 1'b0;
        for (i = 0; i < nb * 8; i++) begin
            di = tx[23 - i];
            #40 sck = 1'b1;
            if (i >= 8 && i < 16) rx[15 - i] = spi_do;
            #40 sck = 1'b0;
        end
        #40 cs_n = 1'b1;
        // Released line shows the inverse of its last bit
        di = ~di;
        #200;
    endtask
endmodule // fsr_host_model
`default_nettype wire

// ===== test/flash_status_config_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_config_registers_tb_top;
    logic       clk, srst, wp_n, hold_n, eng_busy, eng_done, erase_susp, prog_susp;
    wire logic  sck, cs_n, di, spi_do, spi_do_oe, op_permit, busy, gran, dir, inv, quad, hold_act, hw_rst, dcs;
    wire logic [2:0] rng, lck;
    wire logic [1:0] drv;
    int         errors = 0;
    int         total_checks = 0;
    logic [7:0] rd;

    fsr_host_model u_host (.sck(sck), .cs_n(cs_n), .di(di), .spi_do(spi_do));
    fsr_flash_status #(.NV_WRITE_CYCLES(4)) u_dut (
        .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .di(di), .spi_do(spi_do), .spi_do_oe(spi_do_oe),
        .wp_n(wp_n), .hold_n(hold_n), .eng_busy(eng_busy), .eng_done(eng_done), .erase_susp(erase_susp),
        .prog_susp(prog_susp), .op_permit(op_permit), .busy(busy), .granularity_select(gran),
        .direction_select(dir), .protect_range(rng), .invert_protection(inv), .secure_lock(lck),
        .four_lane_enable(quad), .hold_active(hold_act), .hw_reset_req(hw_rst), .drive_strength(drv),
        .dummy_cycle_select(dcs));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [15:0] d, input int nb);
        // Offset keeps link edges off the clk edges
        #7 u_host.frame({op, d}, nb, rd);
        repeat (6) @(posedge clk);
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (busy === 1'b0) return;
        end
        errors++;
        wrap_up();
    endtask

    task automatic t_reset_values;
        cmd(fsr_pkg::OP_RDSR1, 16'h0000, 2);
        chk("reg1", rd, fsr_pkg::SR_RESET);
        cmd(fsr_pkg::OP_RDSR2, 16'h0000, 2);
        chk("reg2", rd, fsr_pkg::SR_RESET);
        cmd(fsr_pkg::OP_RDSR3, 16'h0000, 2);
        chk("reg3", rd, fsr_pkg::SR_RESET);
        cmd(fsr_pkg::OP_WRSR1, 16'h7c00, 2);
        cmd(fsr_pkg::OP_RDSR1, 16'h0000, 2);
        chk("denied", rd, 8'h00);
        chk("oe idle", {7'h00, spi_do_oe}, 8'h00);
        hold_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("hold pin", {6'h00, hold_act, hw_rst}, 8'h02);
        hold_n <= 1'b1;
        cmd(fsr_pkg::OP_VWREN, 16'h0000, 1);
        cmd(fsr_pkg::OP_WRSR1, 16'h8000, 2);
        wp_n <= 1'b0;
        cmd(fsr_pkg::OP_WREN, 16'h0000, 1);
        cmd(fsr_pkg::OP_WRSR1, 16'h0400, 2);
        cmd(fsr_pkg::OP_RDSR1, 16'h0000, 2);
        chk("hw lock", rd, 8'h80);
        wp_n <= 1'b1;
    endtask

    task automatic t_nv_write;
        cmd(fsr_pkg::OP_WREN, 16'h0000, 1);
        chk("latch set", {7'h00, op_permit}, 8'h01);
        cmd(fsr_pkg::OP_WRSR1, 16'h7f4a, 3);
        wait_idle();
        chk("latch clr", {7'h00, op_permit}, 8'h00);
        cmd(fsr_pkg::OP_RDSR1, 16'h0000, 2);
        chk("reg1 ro", rd, 8'h7c);
        cmd(fsr_pkg::OP_RDSR2, 16'h0000, 2);
        chk("reg2 nv", rd, 8'h4a);
        chk("inv lock", {4'h0, inv, lck}, 8'h09);
        chk("prot", {3'h0, gran, dir, rng}, 8'h1f);
        chk("quad", {7'h00, quad}, 8'h01);
    endtask

    task automatic t_volatile;
        cmd(fsr_pkg::OP_VWREN, 16'h0000, 1);
        cmd(fsr_pkg::OP_WRSR3, 16'he100, 2);
        chk("no nv busy", {7'h00, busy}, 8'h00);
        chk("drive", {6'h00, drv}, 8'h03);
        chk("dummy", {7'h00, dcs}, 8'h01);
        hold_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("quad pins", {6'h00, hold_act, hw_rst}, 8'h00);
        hold_n <= 1'b1;
        cmd(fsr_pkg::OP_RSTEN, 16'h0000, 1);
        cmd(fsr_pkg::OP_RST, 16'h0000, 1);
        repeat (20) @(posedge clk);
        chk("reload", {3'h0, drv, rng}, 8'h07);
    endtask

    task automatic t_engine;
        cmd(fsr_pkg::OP_WREN, 16'h0000, 1);
        eng_done <= 1'b1;
        @(posedge clk);
        eng_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("done clr", {7'h00, op_permit}, 8'h00);
        eng_busy   <= 1'b1;
        erase_susp <= 1'b1;
        prog_susp  <= 1'b1;
        repeat (4) @(posedge clk);
        chk("busy", {7'h00, busy}, 8'h01);
        cmd(fsr_pkg::OP_RDSR2, 16'h0000, 2);
        chk("suspend", rd, 8'hce);
        cmd(fsr_pkg::OP_WREN, 16'h0000, 1);
        chk("ignored", {7'h00, op_permit}, 8'h00);
        eng_busy <= 1'b0;
    endtask

    initial begin
        srst       <= 1'b1;
        wp_n       = 1'b1;
        hold_n     = 1'b1;
        eng_busy   = 1'b0;
        eng_done   = 1'b0;
        erase_susp = 1'b0;
        prog_susp  = 1'b0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        t_reset_values();
        t_nv_write();
        t_volatile();
        t_engine();
        wrap_up();
    end
endmodule // flash_status_config_registers_tb_top
`default_nettype wire
